// ===== rtl/pzsram_array.v
// Purpose: Word storage with per-lane write mask
// Assumes: Flip-flop storage, combinational read by index
// Notes:   Contents are never cleared by reset, so sleep keeps them
`timescale 1ns/100ps
`include "pzsram_map.vh"
module pzsram_array #(
   parameter ADDR_BITS = `PZSRAM_ADDR_BITS,
   parameter LANE_BITS = `PZSRAM_LANE_BITS,
   parameter LANES     = `PZSRAM_LANES
) (
   // Clock
   input  wire                         clock,
   // Write port
   input  wire                         writeEn,
   input  wire [ADDR_BITS-1:0]         writeAddr,
   input  wire [LANES-1:0]             laneEn,
   input  wire [LANES*LANE_BITS-1:0]   writeData,
   // Read port
   input  wire [ADDR_BITS-1:0]         readAddr,
   output wire [LANES*LANE_BITS-1:0]   readData
);
   reg [LANES*LANE_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];
   integer i;

   // Only enabled lanes change; masked lanes keep old contents
   always @(posedge clock) begin
      if (writeEn) begin
         for (i = 0; i < LANES; i = i + 1) begin
            if (laneEn[i]) begin
               mem[writeAddr][i*LANE_BITS +: LANE_BITS] <= writeData[i*LANE_BITS +: LANE_BITS];
            end
         end
      end
   end

   assign readData = mem[readAddr];
endmodule // pzsram_array

// ===== rtl/pzsram_core.v
// Purpose: Pipelined synchronous SRAM with zero bus turnaround
// Assumes: All synchronous pins come from logic on clock; output enable and sleep are pins
// Notes:   Data phase is two edges after the command edge
//          Output enable and sleep take effect two edges late, through synchronisers
// Behaviour
// - One active-low write enable per byte lane
// - Lane enables ignored on read commands
// - Enabled lanes stored from bus two cycles later
// - Deselect on load with any select false
// - Bus floats two cycles after deselect
// - Three selects must all be true
// - Synchronous inputs sampled on rising edge
// - Write and read data registered on edge
// - Burst order select picks interleaved or linear
// - Drive bus only while output enable low; drive follows the pin two edges late, through its synchroniser
// - Sleep blocks clock, lowest power
// - Array contents kept through sleep
// - Data phase two cycles after command
// - Clock gate high freezes pipeline and array; output enable still reaches drive through its synchroniser
// - Advance ignores address, steps burst counter
// - Bus floats two cycles after write command
`timescale 1ns/100ps
`include "pzsram_map.vh"
module pzsram_core #(
   parameter ADDR_BITS = `PZSRAM_ADDR_BITS,
   parameter LANE_BITS = `PZSRAM_LANE_BITS,
   parameter LANES     = `PZSRAM_LANES
) (
   // Clock and reset
   input  wire                         clock,
   input  wire                         rst,
   // Command
   input  wire [ADDR_BITS-1:0]         address,
   input  wire                         chip_select_a_n,
   input  wire                         chip_select_b_n,
   input  wire                         chip_select_pos,
   input  wire                         readNotWrite,
   input  wire                         advance_not_load,
   input  wire                         clock_gate_n,
   input  wire [LANES-1:0]             byte_lane_write_n,
   // Static and asynchronous controls
   input  wire                         burst_order_select,
   input  wire                         outputEnable_n,
   input  wire                         sleep_request,
   // Data bus, 32 data bits plus parity_byte_bits in the top lane bits
   input  wire [LANES*LANE_BITS-1:0]   dataBusIn,
   output reg  [LANES*LANE_BITS-1:0]   dataBusOut,
   output wire [LANES*LANE_BITS-1:0]   dataBusOe
);
   localparam WB = LANES*LANE_BITS;
   localparam ST_IDLE  = 3'h1;
   localparam ST_READ  = 3'h2;
   localparam ST_WRITE = 3'h4;

   // Asynchronous pins through two flops
   reg oeMeta, oeSync, sleepMeta, sleepSync;
   reg [2:0]            state;
   reg [ADDR_BITS-1:0]  baseAddr;
   reg [1:0]            burstCnt;
   // Pipeline stages: 1 = one edge after command, 2 = data edge
   reg                  valid1, write1, valid2, write2;
   reg [ADDR_BITS-1:0]  addr1, addr2;
   reg [LANES-1:0]      lane1, lane2;
   reg                  driveBus;
   wire [WB-1:0]        arrayData;

   // Burst address, low two bits only
   function [1:0] burstLow;
      input [1:0] start;
      input [1:0] count;
      input       interleave;
      begin
         if (interleave)
            burstLow = start ^ count;
         else
            burstLow = start + count;
      end
   endfunction

   // Lane write mask from the active-low pins; reads never write a lane
   function [LANES-1:0] laneMask;
      input             isRead;
      input [LANES-1:0] laneN;
      begin
         if (isRead)
            laneMask = {LANES{1'b0}};
         else
            laneMask = ~laneN;
      end
   endfunction

   wire selected  = ~chip_select_a_n & ~chip_select_b_n & chip_select_pos;
   // Sleep gates the internal clock: only the synchronisers move while asleep
   wire tick      = ~clock_gate_n & ~sleepSync;
   wire loadCmd   = ~advance_not_load & selected;
   wire deselect  = ~advance_not_load & ~selected;
   wire advance   = advance_not_load & (state != ST_IDLE);
   wire [1:0] nextCnt = burstCnt + 2'h1;
   // Next burst word: upper bits fixed, low two bits from the counter
   wire [ADDR_BITS-1:0] advAddr = {baseAddr[ADDR_BITS-1:2],
                                   burstLow(baseAddr[1:0], nextCnt, burst_order_select)};

   // Data phase of the command loaded two ticks earlier
   wire readBeat  = valid2 & ~write2;
   wire writeBeat = valid2 & write2;

   // Synchronisers for the asynchronous pins
   // Costs two edges of lag on output enable and sleep, but no pin reaches logic raw
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         oeMeta    <= 1'b0;
         oeSync    <= 1'b0;
         sleepMeta <= 1'b0;
         sleepSync <= 1'b0;
      end else begin
         oeMeta    <= outputEnable_n;
         oeSync    <= oeMeta;
         sleepMeta <= sleep_request;
         sleepSync <= sleepMeta;
      end
   end

   // Second pipeline stage: the command reaches the bus on the next edge
   // Shares the tick with the decode so a gated edge freezes both stages alike
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         valid2 <= 1'b0;
         write2 <= 1'b0;
         addr2  <= {ADDR_BITS{1'b0}};
         lane2  <= {LANES{1'b0}};
      end else if (tick) begin
         valid2 <= valid1;
         write2 <= write1;
         addr2  <= addr1;
         lane2  <= lane1;
      end
   end

   // Command decode and burst counter, first pipeline stage
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state    <= ST_IDLE;
         baseAddr <= {ADDR_BITS{1'b0}};
         burstCnt <= `PZSRAM_CNT_RST;
         valid1   <= 1'b0;
         write1   <= 1'b0;
         addr1    <= {ADDR_BITS{1'b0}};
         lane1    <= {LANES{1'b0}};
      end else if (tick) begin
         // Every state accepts a new load; that is what removes dead cycles
         case (state)
            ST_IDLE, ST_READ, ST_WRITE: begin
               if (loadCmd) begin
                  state    <= readNotWrite ? ST_READ : ST_WRITE;
                  baseAddr <= address;
                  burstCnt <= `PZSRAM_CNT_RST;
                  valid1   <= 1'b1;
                  write1   <= ~readNotWrite;
                  addr1    <= address;
                  // Lanes ignored on reads
                  lane1    <= laneMask(readNotWrite, byte_lane_write_n);
               end else if (deselect) begin
                  state  <= ST_IDLE;
                  valid1 <= 1'b0;
                  write1 <= 1'b0;
                  lane1  <= {LANES{1'b0}};
               end else if (advance) begin
                  // Direction kept from load; address pins ignored
                  burstCnt <= nextCnt;
                  valid1   <= 1'b1;
                  addr1    <= advAddr;
                  // Lanes are sampled again on every burst-write beat
                  lane1    <= laneMask(state != ST_WRITE, byte_lane_write_n);
               end else begin
                  valid1 <= 1'b0;
                  write1 <= 1'b0;
                  lane1  <= {LANES{1'b0}};
               end
            end
            default: begin
               state  <= ST_IDLE;
               valid1 <= 1'b0;
            end
         endcase
      end
   end

   // Read data register and drive flag, both on the data edge
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         dataBusOut <= {WB{1'b0}};
         driveBus   <= 1'b0;
      end else if (tick) begin
         // Low after a write or deselect beat: the host owns the bus then
         driveBus <= readBeat;
         // Held between read beats so a late sample still sees the last word
         if (readBeat)
            dataBusOut <= arrayData;
      end
   end

   // Output enable only removes drive; the pipeline keeps running
   // Limitation: a change on the pin shows here two edges late
   assign dataBusOe = {WB{driveBus & ~oeSync}};

   // Write data taken from the bus at the data edge
   // One address serves both ports, so a read beat sees a written word from the next edge on
   pzsram_array #(
      .ADDR_BITS (ADDR_BITS),
      .LANE_BITS (LANE_BITS),
      .LANES     (LANES)
   ) u_array (
      .clock     (clock),
      .writeEn   (tick & writeBeat),
      .writeAddr (addr2),
      .laneEn    (lane2),
      .writeData (dataBusIn),
      .readAddr  (addr2),
      .readData  (arrayData)
   );
endmodule // pzsram_core

// ===== rtl/pzsram_map.vh
// Purpose: Constants for the pipelined zero-turnaround SRAM model
// Assumes: 36-bit word built from four 9-bit byte lanes
// Notes:   Included by the SRAM core and its storage array
`ifndef PZSRAM_MAP_VH
`define PZSRAM_MAP_VH
`define PZSRAM_LANE_BITS   9
`define PZSRAM_LANES       4
`define PZSRAM_WORD_BITS   36
`define PZSRAM_ADDR_BITS   18
`define PZSRAM_PIPE_DEPTH  2
`define PZSRAM_BURST_LEN   4
`define PZSRAM_CNT_RST     2'h0
`endif

// ===== tb/pzsram_core_properties.sv
// Purpose: Port checks for the SRAM core
// Assumes: Output enable low and sleep low while checked
// Notes:   Gated edges stretch the data phase
`timescale 1ns/100ps
module pzsram_core_properties (
   // Clock, reset and command pins
   input wire clock, rst, chip_select_a_n, chip_select_b_n, chip_select_pos, readNotWrite,
   input wire advance_not_load, clock_gate_n, outputEnable_n, sleep_request,
   // Data outputs
   input wire [35:0] dataBusOut, dataBusOe
);
   // Edges that count, and the decoded command
   wire ok  = !clock_gate_n && !sleep_request && !outputEnable_n;
   wire sel = !chip_select_a_n && !chip_select_b_n && chip_select_pos;
   wire ld  = ok && !advance_not_load;
   wire adv = ok && advance_not_load;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   AST_READ_DRIVE: assert property (ld && sel && readNotWrite ##1 ok ##1 ok |=> &dataBusOe)
      else $error("read beat not driven");
   AST_WRITE_FLOAT: assert property (ld && sel && !readNotWrite ##1 ok ##1 ok |=> dataBusOe == 36'h0)
      else $error("bus driven in write beat");
   AST_DESEL_FLOAT: assert property (ld && !sel ##1 ok ##1 ok |=> dataBusOe == 36'h0)
      else $error("bus driven after deselect");
   AST_BURST_READ: assert property (ld && sel && readNotWrite ##1 adv ##1 ok ##1 ok |=> &dataBusOe)
      else $error("second read beat missing");
   AST_BURST_WRITE: assert property (ld && sel && !readNotWrite ##1 adv ##1 ok ##1 ok |=> !dataBusOe[0])
      else $error("bus driven in burst write");
   AST_IDLE_ADV: assert property (ld && !sel ##1 adv ##1 ok ##1 ok |=> dataBusOe == 36'h0)
      else $error("advance after deselect drove bus");
   AST_GATE_HOLD: assert property (clock_gate_n |=> $stable(dataBusOut) && $stable(dataBusOe))
      else $error("outputs moved on gated edge");
   AST_OUT_REG: assert property (!$stable(dataBusOut) |-> &dataBusOe)
      else $error("read data changed outside a beat");
   // Main scenarios reached
   cover property (ld && sel && readNotWrite ##1 adv);
   cover property (ld && !sel ##1 adv);
   cover property (clock_gate_n ##1 !clock_gate_n);
endmodule // pzsram_core_properties
bind pzsram_core pzsram_core_properties chk_u (.clock, .rst, .chip_select_a_n, .chip_select_b_n,
   .chip_select_pos, .readNotWrite, .advance_not_load, .clock_gate_n, .outputEnable_n, .sleep_request,
   .dataBusOut, .dataBusOe);

// ===== tb/pzsram_host_model.sv
// Purpose: Controller side of the data bus and static pins
// Assumes: Host drives data only in its write beats
// Notes:   A released bus toggles so stale data never matches
`timescale 1ns/100ps
module pzsram_host_model (
   // Bus sides
   input  wire        clock,
   input  wire [35:0] dataBusOut, dataBusOe, hostData,
   input  wire        hostDrive,
   output wire [35:0] dataBusIn,
   // Static pins and the bench's requests for them
   input  wire        orderSel, oeOff,
   output wire        outputEnable_n, burst_order_select
);
   reg [35:0] lastLevel = 36'h0;
   // Wire level: device, host, else a pattern that flips each cycle
   assign dataBusIn = dataBusOe[0] ? dataBusOut : hostDrive ? hostData : ~lastLevel;
   always @(posedge clock) lastLevel <= dataBusIn;
   assign outputEnable_n = oeOff;        // low except in the output-enable scenario
   assign burst_order_select = orderSel; // changed only while reset is held
endmodule // pzsram_host_model

// ===== tb/test_pipelined_zero_turnaround_sram_bus.sv
// Purpose: Self-checking bench for the SRAM core
// Assumes: Interleaved order, linear after a mid-run reset; addresses 0 to 7 only
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
module test_pipelined_zero_turnaround_sram_bus;
   logic clock = 0, rst = 1, chip_select_a_n = 1, chip_select_b_n = 0, chip_select_pos = 1;
   logic readNotWrite = 1, advance_not_load = 0, clock_gate_n = 0, hostDrive = 0;
   logic sleep_request = 0, orderSel = 1, oeOff = 0;
   logic [17:0] address = 18'h0;
   logic [3:0]  byte_lane_write_n = 4'h0;
   logic [35:0] hostData = 36'h0, mem [0:7];
   wire  [35:0] dataBusIn, dataBusOut, dataBusOe;
   wire         outputEnable_n, burst_order_select;
   int          err_count = 0, check_count = 0;
   always #2 clock = ~clock;
   pzsram_host_model host_u (.clock, .dataBusOut, .dataBusOe, .hostData, .hostDrive, .dataBusIn,
      .orderSel, .oeOff, .outputEnable_n, .burst_order_select);
   pzsram_core dut_u (.clock, .rst, .address, .chip_select_a_n, .chip_select_b_n, .chip_select_pos,
      .readNotWrite, .advance_not_load, .clock_gate_n, .byte_lane_write_n, .burst_order_select,
      .outputEnable_n, .sleep_request, .dataBusIn, .dataBusOut, .dataBusOe);
   task chk(input logic good, input string msg);
      check_count++;
      if (!good) begin
         err_count++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask
   // Burst of n beats from a; shadow copy tracks lane-masked writes
   task xfer(input logic r, input [2:0] a, input int n, input [35:0] d0);
      int j;
      logic [2:0] b;
      for (int i = 0; i <= n + 3; i++) begin
         @(negedge clock);
         advance_not_load = (i > 0) && (i < n);
         chip_select_a_n = (i >= n);
         readNotWrite = r;
         address = {15'h0, a};
         hostDrive = !r && i >= 2 && i < n + 2;
         j = i - 2 - r;
         b = {a[2], orderSel ? a[1:0] ^ j[1:0] : a[1:0] + j[1:0]};
         if (hostDrive) begin
            hostData = d0 + 36'(j);
            for (int k = 0; k < 4; k++) if (!byte_lane_write_n[k]) mem[b][9*k +: 9] = hostData[9*k +: 9];
         end
         if (r && i >= 3 && i < n + 3) chk(dataBusOut === mem[b] && dataBusOe === {36{1'b1}}, "read data");
         if (i == n + 3) chk(dataBusOe === 36'h0, "bus not released");
      end
   endtask
   // Two gated edges must not count toward the data phase
   task gated(input [2:0] a);
      @(negedge clock);
      advance_not_load = 0;
      chip_select_a_n = 0;
      readNotWrite = 1;
      address = {15'h0, a};
      @(negedge clock);
      clock_gate_n = 1;
      chip_select_a_n = 1;
      repeat (2) @(negedge clock);
      chk(dataBusOe === 36'h0, "gated edge counted");
      clock_gate_n = 0;
      repeat (2) @(negedge clock);
      chk(dataBusOut === mem[a] && dataBusOe === {36{1'b1}}, "gated read");
   endtask
   // Read with output enable high: data moves, pins stay released
   task oe_high(input [2:0] a);
      oeOff = 1;
      repeat (2) @(negedge clock);
      advance_not_load = 0;
      chip_select_a_n = 0;
      readNotWrite = 1;
      address = {15'h0, a};
      @(negedge clock);
      chip_select_a_n = 1;
      repeat (2) @(negedge clock);
      chk(dataBusOut === mem[a] && dataBusOe === 36'h0, "drove with output enable high");
      oeOff = 0;
   endtask
   // A write given in sleep must not land, and stored words survive
   task asleep(input [2:0] a);
      sleep_request = 1;
      repeat (2) @(negedge clock);
      advance_not_load = 0;
      chip_select_a_n = 0;
      readNotWrite = 0;
      address = {15'h0, a};
      hostData = ~mem[a];
      hostDrive = 1;
      repeat (4) @(negedge clock);
      chk(dataBusOe === 36'h0 && dataBusOut === mem[a], "state moved in sleep");
      chip_select_a_n = 1;
      hostDrive = 0;
      readNotWrite = 1;
      sleep_request = 0;
      repeat (3) @(negedge clock);
   endtask
   // Reset in mid-run to switch to linear order; the array keeps its words
   task relinear;
      @(negedge clock);
      rst = 1;
      orderSel = 0;
      repeat (2) @(negedge clock);
      rst = 0;
      chk(dataBusOe === 36'h0 && dataBusOut === 36'h0, "outputs not cleared by reset");
      xfer(1, 1, 4, 36'h0);
   endtask
   // Each select false in turn, then an advance that must stay idle
   task desel;
      for (int s = 0; s < 3; s++) begin
         @(negedge clock);
         advance_not_load = 0;
         {chip_select_a_n, chip_select_b_n, chip_select_pos} = 3'b001 ^ (3'b100 >> s);
         @(negedge clock);
         {chip_select_a_n, chip_select_b_n, chip_select_pos} = 3'b001;
         advance_not_load = 1;
         repeat (2) begin
            @(negedge clock);
            chk(dataBusOe === 36'h0, "deselect drove bus");
         end
      end
   endtask
   task print_verdict;
      $display("Errors %0d of %0d checks", err_count, check_count);
      if (err_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      @(negedge clock);
      rst = 0;
      chk(dataBusOe === 36'h0 && dataBusOut === 36'h0, "bus driven after reset");
      xfer(0, 0, 4, 36'h123456789);
      xfer(1, 1, 4, 36'h0);
      byte_lane_write_n = 4'ha;
      xfer(0, 2, 1, 36'hfffffffff);
      byte_lane_write_n = 4'h0;
      xfer(1, 2, 1, 36'h0);
      gated(2);
      oe_high(2);
      desel;
      asleep(2);
      xfer(1, 2, 1, 36'h0);
      relinear;
      print_verdict;
   end
   // The whole run needs about 76 cycles; this allows over thirteen times that
   initial begin
      #4000;
      err_count++;
      print_verdict;
   end
endmodule // test_pipelined_zero_turnaround_sram_bus
